// file: hw/ccs_pkg.sv
//Contract
//- new mode applies only after reload; code takes it from the first load after reset only, not on a recompute
//- pin mode: serial pins become channel enables
//- serial mode: pins carry clock and data
//- both straps mid force serial interface
//- sync from soft bit or pin, reference-qualified
//- low level mutes; high releases together
//- per-channel first-edge delay up to 32
//- only included channels take part in sync
//- bypass and pll dividers ignore sync
//- delay step is one pre-scaler period
//- start-up crc over image, report match
//- recompute bit repeats crc and compare
//- crc mismatch reported only, never blocks
//- crc is ccitt sixteen bit polynomial
//- per-block powerdown; bypass follows channel four
//- target port runs at 100 and 400 khz
//- address upper five fixed, lower two selectable
//- mid page strap answers at default address
//- low/high strap: bit one set, bit zero loaded
//- address, 16-bit offset, 16-bit value
//- page strap sampled after power-up
package ccs_pkg;
  localparam int CCS_CHANNELS = 4;
  localparam int CCS_DELAY_MAX = 32;
  localparam int CCS_DELAY_W = 6;
  localparam logic [4:0] CCS_ADDR_HI = 5'h1d;
  localparam logic [1:0] CCS_ADDR_LO_DEFAULT = 2'h0;
  localparam logic [15:0] CCS_CRC_POLY = 16'h1021;
  localparam logic [15:0] CCS_CRC_INIT = 16'hffff;
  localparam logic [5:0] CCS_NVM_LAST_IDX = 6'h3f;
  localparam logic [5:0] CCS_NVM_CRC_IDX = 6'h3f;
  localparam logic [5:0] CCS_NVM_CFG_IDX = 6'h00;
  localparam logic [5:0] CCS_STRAP_WAIT = 6'h2;
  localparam int CCS_MODE_BIT = 0;
  localparam int CCS_A0_BIT = 1;
  localparam logic CCS_MODE_PIN = 1'b1;
  localparam logic [3:0] CCS_BYTES_PER_XFER = 4'h5;
  localparam int CCS_SYS_KHZ = 100000;
  localparam int CCS_SCL_FAST_KHZ = 400;
  localparam int CCS_SCL_STD_KHZ = 100;
  localparam int CCS_SCL_MIN_CYC = CCS_SYS_KHZ / CCS_SCL_FAST_KHZ;
  localparam int CCS_SCL_MIN_OVERSAMPLE = 8;
  typedef enum logic [1:0] {CCS_LVL_LOW, CCS_LVL_MID, CCS_LVL_HIGH} ccs_level_e;
  typedef logic [CCS_DELAY_W-1:0] ccs_delay_t;
endpackage

// file: hw/ccs_sync.sv
`timescale 1ns/1ps
module ccs_sync #(
  parameter int CH = 4,
  parameter int DW = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // sync control and channel state
  ccs_sync_if.chan sif
);
  import ccs_pkg::*;

  logic done_q;
  logic done_d;
  logic [CH-1:0] mute_q;
  logic [CH-1:0] mute_d;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel release counters
  for (genvar i = 0; i < CH; i++) begin : g_ch
    logic [DW-1:0] cnt_q;
    logic [DW-1:0] cnt_d;
    always_comb begin
      cnt_d = cnt_q;
      mute_d[i] = mute_q[i];
      if (!sif.incl[i]) begin
        mute_d[i] = 1'b0;
        cnt_d = '0;
      end else if (!sif.level) begin
        mute_d[i] = 1'b1;
        cnt_d = sif.delay[i*DW +: DW];
      end else if (mute_q[i]) begin
        // every channel starts counting on the same qualified edge
        if (cnt_q == '0) begin
          mute_d[i] = 1'b0;
        end else if (sif.tick) begin
          cnt_d = cnt_q - 1'b1;
        end
      end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    done_d = ~(|mute_d);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mute_q <= '0;
      done_q <= 1'b1;
    end else begin
      mute_q <= mute_d;
      done_q <= done_d;
    end
  end

  assign sif.mute = mute_q;
  assign sif.done = done_q;
endmodule

// file: hw/ccs_sync_if.sv
`timescale 1ns/1ps
interface ccs_sync_if #(
  parameter int CH = 4,
  parameter int DW = 6
);
  logic level;
  logic tick;
  logic [CH-1:0] incl;
  logic [CH*DW-1:0] delay;
  logic [CH-1:0] mute;
  logic done;
  modport ctl (output level, tick, incl, delay, input mute, done);
  modport chan (input level, tick, incl, delay, output mute, done);
endinterface

// file: hw/ccs_top.sv
`timescale 1ns/1ps
module ccs_top #(
  parameter int CH = ccs_pkg::CCS_CHANNELS,
  parameter int DW = ccs_pkg::CCS_DELAY_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // strap pins, decoded tri-level
  input wire ccs_pkg::ccs_level_e reference_select_pin,
  input wire ccs_pkg::ccs_level_e page_select_pin,
  // control pins
  input wire logic active_low_reset_pin,
  input wire logic pfd_reference_clock,
  input wire logic prescaler_tick,
  input wire logic channel_one_enable_input,
  input wire logic pin11_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic pin20_out,
  output logic pin20_oe_n,
  // nvm read port
  output logic nvm_rd_req,
  output logic [6:0] nvm_rd_addr,
  input wire logic nvm_rd_ack,
  input wire logic [15:0] nvm_rd_data,
  // register access from the serial port
  output logic reg_wr_valid,
  output logic [15:0] reg_offset,
  output logic [15:0] reg_wr_data,
  input wire logic [15:0] reg_rd_data,
  // control bits
  input wire logic sync_soft,
  input wire logic update_crc,
  input wire logic pin_zero_input_function,
  input wire logic [CH-1:0] channel_sync_include,
  input wire logic [CH*DW-1:0] channel_first_edge_delay,
  input wire logic [CH-1:0] channel_powerdown_in,
  // status
  output logic crc_match,
  output logic [15:0] live_crc,
  output logic load_done,
  output logic mode_serial,
  output logic page_address_lsb,
  output logic page_sel,
  output logic sync_done,
  output logic [CH-1:0] channel_enable,
  output logic [CH-1:0] channel_mute,
  output logic [CH-1:0] channel_powerdown,
  output logic bypass_powerdown
);
  import ccs_pkg::*;

  if (CH != CCS_CHANNELS || DW < $clog2(CCS_DELAY_MAX + 1)) begin : g_chk
    $error("ccs_top: channel count or delay width unsupported");
  end
  if (CCS_SCL_MIN_CYC < CCS_SCL_MIN_OVERSAMPLE) begin : g_chk_clk
    $error("ccs_top: system clock too slow for fast-mode scl");
  end

  typedef enum {LD_STRAP, LD_REQ, LD_WAIT, LD_IDLE} ccs_ld_e;
  typedef enum {I2_IDLE, I2_RX, I2_ACK, I2_TX, I2_TXACK} ccs_i2_e;

  function automatic logic [15:0] ccs_crc_word(input logic [15:0] crc, input logic [15:0] data);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int b = 15; b >= 0; b--) begin
      fb = c[15] ^ data[b];
      c = {c[14:0], 1'b0} ^ (fb ? CCS_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: stage one feeds stage two only
  localparam int NS = 11;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s3_q;
  assign pin_raw = {reference_select_pin, page_select_pin, active_low_reset_pin, pfd_reference_clock,
                    prescaler_tick, channel_one_enable_input, pin11_in, scl_in, sda_in};
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  ccs_level_e ref_lvl;
  ccs_level_e page_lvl;
  logic sync_pin;
  logic pfd_rise;
  logic tick_rise;
  logic scl_s;
  logic sda_s;
  logic scl_p;
  logic sda_p;
  assign ref_lvl = ccs_level_e'(s2_q[10:9]);
  assign page_lvl = ccs_level_e'(s2_q[8:7]);
  assign sync_pin = s2_q[6];
  assign pfd_rise = s2_q[5] & ~s3_q[5];
  assign tick_rise = s2_q[4] & ~s3_q[4];
  assign scl_s = s2_q[1];
  assign sda_s = s2_q[0];
  assign scl_p = s3_q[1];
  assign sda_p = s3_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // start-up load and crc check
  ccs_ld_e ld_q, ld_d;
  logic [5:0] idx_q, idx_d;
  logic [15:0] crc_q, crc_d;
  logic [15:0] live_q, live_d;
  logic match_q, match_d;
  logic first_q, first_d;
  logic fallback_q, fallback_d;
  logic page_q, page_d;
  logic mid_q, mid_d;
  logic mode_q, mode_d;
  logic a0_q, a0_d;
  logic done_q, done_d;
  logic rerun_q, rerun_d;
  logic req_q, req_d;

  always_comb begin
    ld_d = ld_q;
    idx_d = idx_q;
    crc_d = crc_q;
    live_d = live_q;
    match_d = match_q;
    first_d = first_q;
    fallback_d = fallback_q;
    page_d = page_q;
    mid_d = mid_q;
    mode_d = mode_q;
    a0_d = a0_q;
    done_d = done_q;
    req_d = 1'b0;
    rerun_d = rerun_q | update_crc;
    case (ld_q)
      LD_STRAP: begin
        // straps are read once the synchronisers have filled; idx counts the edges until then
        idx_d = idx_q + 1'b1;
        if (idx_q == CCS_STRAP_WAIT) begin
          page_d = (page_lvl == CCS_LVL_HIGH);
          mid_d = (page_lvl == CCS_LVL_MID);
          fallback_d = (ref_lvl == CCS_LVL_MID) && (page_lvl == CCS_LVL_MID);
          idx_d = '0;
          ld_d = LD_REQ;
        end
      end
      LD_REQ: begin
        req_d = 1'b1;
        ld_d = LD_WAIT;
      end
      LD_WAIT: begin
        if (nvm_rd_ack) begin
          if (idx_q == CCS_NVM_CRC_IDX) begin
            match_d = (crc_q == nvm_rd_data);
            live_d = crc_q;
          end else begin
            crc_d = ccs_crc_word(crc_q, nvm_rd_data);
          end
          if (first_q && idx_q == CCS_NVM_CFG_IDX) begin
            mode_d = nvm_rd_data[CCS_MODE_BIT];
            a0_d = nvm_rd_data[CCS_A0_BIT];
          end
          if (idx_q == CCS_NVM_LAST_IDX) begin
            first_d = 1'b0;
            done_d = 1'b1;
            ld_d = LD_IDLE;
          end else begin
            idx_d = idx_q + 1'b1;
            ld_d = LD_REQ;
          end
        end
      end
      LD_IDLE: begin
        if (rerun_q) begin
          rerun_d = update_crc;
          idx_d = '0;
          crc_d = CCS_CRC_INIT;
          ld_d = LD_REQ;
        end
      end
      default: ld_d = LD_STRAP;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ld_q <= LD_STRAP;
      idx_q <= '0;
      crc_q <= CCS_CRC_INIT;
      live_q <= '0;
      match_q <= 1'b0;
      first_q <= 1'b1;
      fallback_q <= 1'b0;
      page_q <= 1'b0;
      mid_q <= 1'b0;
      mode_q <= 1'b0;
      a0_q <= 1'b0;
      done_q <= 1'b0;
      rerun_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      ld_q <= ld_d;
      idx_q <= idx_d;
      crc_q <= crc_d;
      live_q <= live_d;
      match_q <= match_d;
      first_q <= first_d;
      fallback_q <= fallback_d;
      page_q <= page_d;
      mid_q <= mid_d;
      mode_q <= mode_d;
      a0_q <= a0_d;
      done_q <= done_d;
      rerun_q <= rerun_d;
      req_q <= req_d;
    end
  end

  logic serial;
  logic [1:0] addr_lo;
  assign serial = fallback_q | (mode_q != CCS_MODE_PIN);
  assign addr_lo = mid_q ? CCS_ADDR_LO_DEFAULT : {1'b1, a0_q};

  ////////////////////////////////////////////////////////////////////////////
  // serial target port; oversampled at 250 clocks per fast-mode bit
  ccs_i2_e i2_q, i2_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] byte_q, byte_d;
  logic rw_q, rw_d;
  logic ackok_q, ackok_d;
  logic [15:0] ofs_q, ofs_d;
  logic [15:0] rdat_q, rdat_d;
  logic [7:0] whi_q, whi_d;
  logic [15:0] wdat_q, wdat_d;
  logic wr_q, wr_d;
  logic oe_n_q, oe_n_d;
  logic start_c, stop_c, rise_c, fall_c;

  always_comb begin
    start_c = scl_s & scl_p & sda_p & ~sda_s;
    stop_c = scl_s & scl_p & ~sda_p & sda_s;
    rise_c = scl_s & ~scl_p;
    fall_c = ~scl_s & scl_p;
    i2_d = i2_q;
    sh_d = sh_q;
    bit_d = bit_q;
    byte_d = byte_q;
    rw_d = rw_q;
    ackok_d = ackok_q;
    ofs_d = ofs_q;
    rdat_d = rdat_q;
    whi_d = whi_q;
    wdat_d = wdat_q;
    wr_d = 1'b0;
    oe_n_d = oe_n_q;
    if (!serial || !done_q) begin
      i2_d = I2_IDLE;
      oe_n_d = 1'b1;
    end else if (start_c) begin
      i2_d = I2_RX;
      bit_d = '0;
      byte_d = '0;
      oe_n_d = 1'b1;
    end else if (stop_c) begin
      i2_d = I2_IDLE;
      oe_n_d = 1'b1;
    end else begin
      case (i2_q)
        I2_IDLE: oe_n_d = 1'b1;
        I2_RX: begin
          if (rise_c && bit_q < 4'h8) begin
            sh_d = {sh_q[6:0], sda_s};
            bit_d = bit_q + 1'b1;
          end else if (fall_c && bit_q == 4'h8) begin
            i2_d = I2_ACK;
            oe_n_d = 1'b0;
            byte_d = byte_q + 1'b1;
            case (byte_q)
              4'h0: begin
                if (sh_q[7:3] == CCS_ADDR_HI && sh_q[2:1] == addr_lo) begin
                  rw_d = sh_q[0];
                  rdat_d = reg_rd_data;
                end else begin
                  i2_d = I2_IDLE;
                  oe_n_d = 1'b1;
                end
              end
              4'h1: ofs_d[15:8] = sh_q;
              4'h2: ofs_d[7:0] = sh_q;
              4'h3: whi_d = sh_q;
              4'h4: begin
                wdat_d = {whi_q, sh_q};
                wr_d = 1'b1;
              end
              default: begin
                i2_d = I2_IDLE;
                oe_n_d = 1'b1;
              end
            endcase
          end
        end
        I2_ACK: begin
          if (fall_c) begin
            bit_d = '0;
            if (rw_q) begin
              i2_d = I2_TX;
              oe_n_d = rdat_q[15];
            end else begin
              i2_d = I2_RX;
              oe_n_d = 1'b1;
            end
          end
        end
        I2_TX: begin
          if (fall_c) begin
            rdat_d = {rdat_q[14:0], 1'b0};
            bit_d = bit_q + 1'b1;
            if (bit_q == 4'h7) begin
              i2_d = I2_TXACK;
              oe_n_d = 1'b1;
            end else begin
              oe_n_d = rdat_q[14];
            end
          end
        end
        I2_TXACK: begin
          if (rise_c) begin
            ackok_d = ~sda_s;
          end else if (fall_c) begin
            bit_d = '0;
            i2_d = ackok_q ? I2_TX : I2_IDLE;
            oe_n_d = ackok_q ? rdat_q[15] : 1'b1;
          end
        end
        default: i2_d = I2_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      i2_q <= I2_IDLE;
      sh_q <= '0;
      bit_q <= '0;
      byte_q <= '0;
      rw_q <= 1'b0;
      ackok_q <= 1'b0;
      ofs_q <= '0;
      rdat_q <= '0;
      whi_q <= '0;
      wdat_q <= '0;
      wr_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      i2_q <= i2_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      rw_q <= rw_d;
      ackok_q <= ackok_d;
      ofs_q <= ofs_d;
      rdat_q <= rdat_d;
      whi_q <= whi_d;
      wdat_q <= wdat_d;
      wr_q <= wr_d;
      oe_n_q <= oe_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync qualification, enables and power-down
  ccs_sync_if #(.CH(CH), .DW(DW)) sif ();
  logic qual_q, qual_d;
  logic tick_q, tick_d;
  logic [CH-1:0] en_q, en_d;
  logic [CH-1:0] pdn_q, pdn_d;
  logic byp_q, byp_d;
  logic p20_oe_n_q, p20_oe_n_d, ser_q, ser_d;

  always_comb begin
    qual_d = qual_q;
    // pin is only looked at on a reference edge, so release aligns to it
    if (pfd_rise) begin
      qual_d = ~sync_soft & (~pin_zero_input_function | sync_pin);
    end
    tick_d = tick_rise;
    en_d = '0;
    if (done_q) begin
      if (serial) begin
        en_d = {CH{s2_q[2]}};
      end else begin
        en_d = {s2_q[2], s2_q[1], s2_q[0], s2_q[3]};
      end
    end
    pdn_d = channel_powerdown_in;
    byp_d = channel_powerdown_in[CH-1];
    p20_oe_n_d = ~fallback_q;
    ser_d = serial;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      qual_q <= 1'b0;
      tick_q <= 1'b0;
      en_q <= '0;
      pdn_q <= '0;
      byp_q <= 1'b0;
      p20_oe_n_q <= 1'b1;
      ser_q <= 1'b0;
    end else begin
      qual_q <= qual_d;
      tick_q <= tick_d;
      en_q <= en_d;
      pdn_q <= pdn_d;
      byp_q <= byp_d;
      p20_oe_n_q <= p20_oe_n_d;
      ser_q <= ser_d;
    end
  end

  assign sif.level = qual_q;
  assign sif.tick = tick_q;
  assign sif.incl = channel_sync_include;
  assign sif.delay = channel_first_edge_delay;

  ccs_sync #(.CH(CH), .DW(DW)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_q;
  assign pin20_out = sif.done;
  assign pin20_oe_n = p20_oe_n_q;
  assign nvm_rd_req = req_q;
  assign nvm_rd_addr = {page_q, idx_q};
  assign reg_wr_valid = wr_q;
  assign reg_offset = ofs_q;
  assign reg_wr_data = wdat_q;
  assign crc_match = match_q;
  assign live_crc = live_q;
  assign load_done = done_q;
  assign mode_serial = ser_q;
  assign page_address_lsb = a0_q;
  assign page_sel = page_q;
  assign sync_done = sif.done;
  assign channel_enable = en_q;
  assign channel_mute = sif.mute;
  assign channel_powerdown = pdn_q;
  assign bypass_powerdown = byp_q;
endmodule

// file: verification/ccs_host_model.sv
`timescale 1ns/1ps
module ccs_host_model (
  // clock
  input wire logic clk_sys,
  // nvm read port
  input wire logic nvm_rd_req,
  input wire logic [6:0] nvm_rd_addr,
  output logic nvm_rd_ack,
  output logic [15:0] nvm_rd_data,
  // serial pins
  input wire logic sda_oe_n,
  output logic scl_in,
  output logic sda_in
);
  logic [15:0] mem [128];
  logic host_sda;
  int lat;
  int hp;
  // open-drain line with pull-up: high unless someone pulls low
  assign sda_in = host_sda & sda_oe_n;
  initial begin
    nvm_rd_ack = 1'b0;
    nvm_rd_data = 16'h0;
    scl_in = 1'b1;
    host_sda = 1'b1;
    lat = 0;
    hp = 125;
    forever begin
      @(negedge clk_sys);
      nvm_rd_ack = 1'b0;
      // idle data keeps toggling so a stray capture never sees a stale word
      nvm_rd_data = ~nvm_rd_data;
      if (nvm_rd_req) begin
        repeat (lat) begin
          @(negedge clk_sys);
          nvm_rd_data = ~nvm_rd_data;
        end
        nvm_rd_ack = 1'b1;
        nvm_rd_data = mem[nvm_rd_addr];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic start();
    host_sda = 1'b1;
    scl_in = 1'b1;
    wt(hp);
    host_sda = 1'b0;
    wt(hp);
    scl_in = 1'b0;
  endtask
  // data moves only mid-low so it is never read as a start or stop
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      wt(hp / 2);
      host_sda = (i == 0) ? 1'b1 : b[i-1];
      wt(hp / 2);
      scl_in = 1'b1;
      wt(hp / 2);
      ack = ~sda_in;
      wt(hp / 2);
      scl_in = 1'b0;
    end
  endtask
  task automatic stop();
    wt(hp / 2);
    host_sda = 1'b0;
    wt(hp / 2);
    scl_in = 1'b1;
    wt(hp);
    host_sda = 1'b1;
    wt(hp);
  endtask
endmodule

// file: verification/ccs_top_assertions.sv
`timescale 1ns/1ps
module ccs_top_assertions #(
  parameter int CH = 4,
  parameter int DW = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // watched inputs
  input wire logic sync_soft,
  input wire logic [CH-1:0] channel_sync_include,
  input wire logic [CH*DW-1:0] channel_first_edge_delay,
  input wire logic [CH-1:0] channel_powerdown_in,
  input wire logic nvm_rd_ack,
  // watched outputs
  input wire logic nvm_rd_req,
  input wire logic [6:0] nvm_rd_addr,
  input wire logic sda_oe_n,
  input wire logic pin20_oe_n,
  input wire logic reg_wr_valid,
  input wire logic load_done,
  input wire logic mode_serial,
  input wire logic page_sel,
  input wire logic [CH-1:0] channel_mute,
  input wire logic [CH-1:0] channel_powerdown,
  input wire logic bypass_powerdown
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // saturating, so a long soft sync never wraps back under the threshold
  logic [4:0] soft_cnt_q;
  logic [4:0] soft_cnt_d;
  always_comb begin
    soft_cnt_d = soft_cnt_q;
    if (!(sync_soft && channel_sync_include[0])) begin
      soft_cnt_d = 5'h0;
    end else if (soft_cnt_q != 5'h1f) begin
      soft_cnt_d = soft_cnt_q + 5'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      soft_cnt_q <= 5'h0;
    end else begin
      soft_cnt_q <= soft_cnt_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_SOFT_MUTE: assert property (soft_cnt_q >= 5'h14 |-> channel_mute[0])
    else $error("included channel not muted by software sync");
  AST_EXCL_FREE: assert property ((channel_mute & ~(channel_sync_include |
    $past(channel_sync_include) | $past(channel_sync_include, 2) | $past(channel_sync_include, 3))) == '0)
    else $error("excluded channel muted");
  AST_TOGETHER: assert property ($fell(channel_mute[0]) && $past(channel_mute[1]) &&
    channel_first_edge_delay[DW-1:0] == channel_first_edge_delay[2*DW-1:DW] |-> !channel_mute[1])
    else $error("equal-delay channels released apart");
  AST_BYPASS_PD: assert property ($past(rstn) |-> bypass_powerdown == channel_powerdown[3] &&
    channel_powerdown == $past(channel_powerdown_in))
    else $error("bypass powerdown not tied to channel four");
  AST_NO_ACK: assert property (!(mode_serial && load_done) |-> sda_oe_n)
    else $error("serial data driven outside serial mode");
  AST_FALLBACK: assert property (!pin20_oe_n |-> mode_serial)
    else $error("fallback pin output without serial mode");
  AST_PAGE: assert property (nvm_rd_req |-> nvm_rd_addr[6] == page_sel)
    else $error("nvm read from wrong page");
  AST_NVM_ORDER: assert property (nvm_rd_ack && nvm_rd_addr[5:0] != 6'h3f |-> ##2
    nvm_rd_req && nvm_rd_addr[5:0] == $past(nvm_rd_addr[5:0], 2) + 6'h1)
    else $error("nvm image not read in ascending order");
  cover property (reg_wr_valid);
  cover property ($fell(channel_mute[2]));
  cover property (nvm_rd_ack && nvm_rd_addr[5:0] == 6'h3f);
endmodule

bind ccs_top ccs_top_assertions #(.CH(CH), .DW(DW)) ccs_top_assertions_i (
  .clk_sys, .rstn, .sync_soft, .channel_sync_include, .channel_first_edge_delay, .channel_powerdown_in,
  .nvm_rd_ack, .nvm_rd_req, .nvm_rd_addr, .sda_oe_n, .pin20_oe_n, .reg_wr_valid, .load_done,
  .mode_serial, .page_sel, .channel_mute, .channel_powerdown, .bypass_powerdown
);

// file: verification/tb_clockgen_config_sync_control.sv
`timescale 1ns/1ps
module tb_clockgen_config_sync_control;
  import ccs_pkg::*;
  logic clk_sys, rstn, active_low_reset_pin, channel_one_enable_input, pin11_in, scl_in, sda_in, sda_oe_n;
  logic pin20_oe_n, nvm_rd_req, nvm_rd_ack, reg_wr_valid, sync_soft, update_crc, pin_zero_input_function;
  logic crc_match, load_done, mode_serial, page_address_lsb, page_sel, sync_done, bypass_powerdown, tprev;
  logic [2:0] ph;
  logic [6:0] nvm_rd_addr;
  logic [15:0] nvm_rd_data, reg_offset, reg_wr_data, live_crc, last_ofs, last_dat;
  logic [3:0] channel_sync_include, channel_powerdown_in, channel_enable, channel_mute, channel_powerdown;
  logic [23:0] channel_first_edge_delay;
  ccs_level_e reference_select_pin, page_select_pin;
  int failures, checked, cycles, ticks, wr_cnt, acks_n, t0;
  ccs_top ccs_top_i (.clk_sys, .rstn, .reference_select_pin, .page_select_pin, .active_low_reset_pin,
    .pfd_reference_clock(ph[2]), .prescaler_tick(ph[1]), .channel_one_enable_input, .pin11_in, .scl_in, .sda_in,
    .sda_out(), .sda_oe_n, .pin20_out(), .pin20_oe_n, .nvm_rd_req, .nvm_rd_addr, .nvm_rd_ack, .nvm_rd_data,
    .reg_wr_valid, .reg_offset, .reg_wr_data, .reg_rd_data(16'h0), .sync_soft, .update_crc,
    .pin_zero_input_function, .channel_sync_include, .channel_first_edge_delay, .channel_powerdown_in,
    .crc_match, .live_crc, .load_done, .mode_serial, .page_address_lsb, .page_sel, .sync_done,
    .channel_enable, .channel_mute, .channel_powerdown, .bypass_powerdown);
  ccs_host_model ccs_host_model_i (.clk_sys, .nvm_rd_req, .nvm_rd_addr, .nvm_rd_ack, .nvm_rd_data,
    .sda_oe_n, .scl_in, .sda_in);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) ph <= ph + 3'h1;
  always @(posedge clk_sys) begin
    tprev <= ph[1];
    ticks <= ticks + int'(ph[1] && !tprev);
    acks_n <= acks_n + int'(nvm_rd_ack);
    if (reg_wr_valid) begin
      wr_cnt <= wr_cnt + 1;
      last_ofs <= reg_offset;
      last_dat <= reg_wr_data;
    end
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      failures++;
      final_report();
    end
  end
  task automatic final_report();
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  function automatic logic [15:0] crc_of(input int pg);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < 63; i++)
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ ccs_host_model_i.mem[pg*64+i][b]) ? 16'h1021 : 16'h0);
    return c;
  endfunction
  task automatic fill(input int pg, input logic [15:0] w0);
    for (int i = 1; i < 63; i++) ccs_host_model_i.mem[pg*64+i] = 16'(i) * 16'h0b3d ^ 16'h5a00;
    ccs_host_model_i.mem[pg*64] = w0;
    ccs_host_model_i.mem[pg*64+63] = crc_of(pg);
  endtask
  task automatic boot(input ccs_level_e r, input ccs_level_e p);
    reference_select_pin = r;
    page_select_pin = p;
    rstn = 1'b0;
    cyc(16);
    rstn = 1'b1;
    for (int k = 0; k < 3000 && load_done !== 1'b1; k++) cyc(1);
    chk(load_done, 1);
  endtask
  task automatic xfer(input logic [7:0] a, input logic [15:0] o, d, input int n, hp, input logic [4:0] ea);
    logic [39:0] by;
    logic [4:0] ack;
    int w0;
    by = {a, o, d};
    ack = 5'h0;
    w0 = wr_cnt;
    ccs_host_model_i.hp = hp;
    ccs_host_model_i.start();
    for (int i = 0; i < n; i++) ccs_host_model_i.put(by[39-8*i -: 8], ack[4-i]);
    ccs_host_model_i.stop();
    chk(ack, ea);
    if (n == 5) begin
      chk(wr_cnt - w0, 1);
      chk({last_ofs, last_dat}, {o, d});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, channel_one_enable_input, pin11_in, sync_soft, update_crc, pin_zero_input_function} = 6'h0;
    {ph, tprev, failures, checked, cycles, ticks, wr_cnt, acks_n} = '0;
    active_low_reset_pin = 1'b1;
    channel_sync_include = 4'h7;
    channel_first_edge_delay = {6'h05, 6'h20, 6'h00, 6'h00};
    channel_powerdown_in = 4'h0;
    fill(0, 16'h0002);
    fill(1, 16'h0001);
    boot(CCS_LVL_LOW, CCS_LVL_LOW);
    chk(crc_match, 1);
    chk(live_crc, crc_of(0));
    chk({mode_serial, page_address_lsb, page_sel}, 3'h6);
    for (int e = 0; e < 2; e++) begin
      pin11_in = e[0];
      cyc(8);
      chk(channel_enable, {4{e[0]}});
    end
    for (int s = 0; s < 2; s++) begin
      sync_soft = (s == 0);
      pin_zero_input_function = s[0];
      active_low_reset_pin = (s == 0);
      cyc(40);
      chk({sync_done, channel_mute}, 5'h07);
      sync_soft = 1'b0;
      active_low_reset_pin = 1'b1;
      for (int k = 0; k < 100 && channel_mute[0]; k++) cyc(1);
      t0 = ticks;
      chk(channel_mute, 4'h4);
      for (int k = 0; k < 400 && channel_mute[2]; k++) cyc(1);
      chk(ticks - t0 == 31 || ticks - t0 == 32, 1);
      cyc(4);
      chk({sync_done, channel_mute}, 5'h10);
    end
    for (int i = 0; i < 2; i++) begin
      channel_powerdown_in = i ? 4'h7 : 4'h8;
      cyc(3);
      chk({bypass_powerdown, channel_powerdown}, {channel_powerdown_in[3], channel_powerdown_in});
    end
    xfer(8'hee, 16'h0044, 16'ha5c3, 5, 125, 5'h1f);
    xfer(8'he8, 16'h0, 16'h0, 1, 125, 5'h0);
    ccs_host_model_i.mem[0] = 16'h0003;
    t0 = acks_n;
    update_crc = 1'b1;
    cyc(1);
    update_crc = 1'b0;
    for (int k = 0; k < 2000 && acks_n - t0 < 64; k++) cyc(1);
    cyc(4);
    chk({crc_match, load_done, mode_serial}, 3'h3);
    chk(live_crc, crc_of(0));
    xfer(8'hee, 16'h0000, 16'h1234, 5, 125, 5'h1f);
    ccs_host_model_i.lat = 3;
    boot(CCS_LVL_HIGH, CCS_LVL_HIGH);
    chk({crc_match, mode_serial, page_address_lsb, page_sel}, 4'h9);
    for (int i = 0; i < 4; i++) begin
      {pin11_in, ccs_host_model_i.scl_in, ccs_host_model_i.host_sda, channel_one_enable_input} = 4'h1 << i;
      cyc(8);
      chk(channel_enable, 4'h1 << i);
    end
    {ccs_host_model_i.scl_in, ccs_host_model_i.host_sda} = 2'h3;
    fill(0, 16'h0001);
    ccs_host_model_i.lat = 0;
    boot(CCS_LVL_MID, CCS_LVL_MID);
    chk({pin20_oe_n, mode_serial}, 2'h1);
    xfer(8'he8, 16'h0010, 16'h00ff, 5, 500, 5'h1f);
    final_report();
  end
endmodule
